// ===== dpsram_top.sv
// Function
// - Read address is taken on the true input clock rising edge.
// - Write address is taken on the complementary input clock rising edge.
// - Each read or write moves exactly two 18-bit words.
// - Address inputs are ignored when neither port is selected.
// - Read select low at true edge registers address and starts read burst.
// - Write select low at true edge starts a write cycle unless a burst waits for buffer room.
// - A byte is stored only when its enable is low during a write.
// - Low enable covers bits 0-8, high enable covers bits 9-17.
// - Byte enables are sampled at both edges, one pair per word.
// - Selects sampled on true edge only; write data on both edges.
// - First read word on output clock edge, second on its complement.
// - Output clocks both high: read data timed from input clock pair.
// - Read data appears only after the next true input clock edge.
// - Reads see data still pending in the write buffer, not stale array.
// - Read data outputs are released whenever no read word is delivered.
`timescale 1ns/1ps
`default_nettype none
module dpsram_top
  import dpsram_pkg::*;
(
  input  wire logic              CLK_I,              // 20 MHz system clock
  input  wire logic              SRST_I,             // Synchronous reset, active high
  input  wire logic              K_I,                // Input clock, true
  input  wire logic              K_N_I,              // Input clock, complementary
  input  wire logic              C_I,                // Output clock, true
  input  wire logic              C_N_I,              // Output clock, complementary
  input  wire logic              RD_SEL_N_I,         // Read port select, active low
  input  wire logic              WR_SEL_N_I,         // Write port select, active low
  input  wire logic [ADDR_W-1:0] SHARED_ADDR_IN_I,   // Shared address bus
  input  wire logic              BYTE_WRITE_LO_N_I,  // Byte write enable bits 8:0, low
  input  wire logic              BYTE_WRITE_HI_N_I,  // Byte write enable bits 17:9, low
  input  wire logic [WORD_W-1:0] WR_DATA_I,          // Write data port
  output logic      [WORD_W-1:0] RD_DATA_O,          // Read data port
  output logic                   RD_DATA_OE_O        // Read data drive enable
);

  typedef enum {FETCH_IDLE, FETCH_W0, FETCH_W1} dpsram_fetch_t;

  // Pin edges, all seen as levels sampled on CLK_I
  logic k_reg, kn_reg, c_reg, cn_reg;
  wire  k_rise  = K_I & ~k_reg;
  wire  kn_rise = K_N_I & ~kn_reg;
  wire  c_rise  = C_I & ~c_reg;
  wire  cn_rise = C_N_I & ~cn_reg;
  // Output clocks parked high select the single clock pair
  wire  single_mode = C_I & C_N_I & c_reg & cn_reg;
  wire  out_first   = single_mode ? k_rise : c_rise;
  wire  out_second  = single_mode ? kn_rise : cn_rise;

  // Write capture register
  logic           wr_open_reg;    // Word 0 taken, waiting for address edge
  logic           wr_full_reg;    // Burst complete, waiting for buffer room
  dpsram_wburst_t wr_reg;

  wire rd_start = k_rise & ~RD_SEL_N_I;
  wire wr_start = k_rise & ~WR_SEL_N_I;
  wire [LANES-1:0] be_pins = {~BYTE_WRITE_HI_N_I, ~BYTE_WRITE_LO_N_I};

  // Two-entry write buffer; entry 0 is always the oldest
  dpsram_wburst_t wbuf_reg [WBUF_DEPTH];
  logic [1:0]     wbuf_cnt_reg;
  logic           drain_word_reg;
  logic           mem_rd_busy;
  wire  wbuf_in_valid  = wr_full_reg;
  wire  wbuf_out_valid = (wbuf_cnt_reg != CNT_RST);
  wire  wbuf_out_ready = ~mem_rd_busy;
  wire  drain_word_en  = wbuf_out_valid & wbuf_out_ready;
  wire  wbuf_pop       = drain_word_en & drain_word_reg;
  wire  wbuf_in_ready  = (wbuf_cnt_reg < 2'(WBUF_DEPTH)) | wbuf_pop;
  wire  wbuf_push      = wbuf_in_valid & wbuf_in_ready;

  // Read fetch engine
  dpsram_fetch_t     fetch_state_reg, fetch_state_next;
  logic [ADDR_W-1:0] rd_addr_reg;
  logic              ret_vld_reg;
  logic              ret_word_reg;
  logic [WORD_W-1:0] fw0_reg, fw1_reg;
  logic              fdone_reg;
  logic [WORD_W-1:0] mem_rdata;

  assign mem_rd_busy = (fetch_state_reg != FETCH_IDLE);
  wire   fetch_word  = (fetch_state_reg == FETCH_W1);

  always_comb begin
    case (fetch_state_reg)
      FETCH_IDLE: fetch_state_next = FETCH_IDLE;
      FETCH_W0:   fetch_state_next = FETCH_W1;
      FETCH_W1:   fetch_state_next = FETCH_IDLE;
      default:    fetch_state_next = FETCH_IDLE;
    endcase
    if (rd_start) begin
      fetch_state_next = FETCH_W0;
    end
  end

  // Memory port: reads win, the buffer drains in free cycles
  wire                  mem_en    = mem_rd_busy | drain_word_en;
  wire                  mem_we    = ~mem_rd_busy;
  wire [MEM_AW-1:0]     mem_addr  = mem_rd_busy ? {rd_addr_reg, fetch_word}
                                                : {wbuf_reg[0].addr, drain_word_reg};
  wire [LANES-1:0]      mem_be    = drain_word_reg ? wbuf_reg[0].be1 : wbuf_reg[0].be0;
  wire [WORD_W-1:0]     mem_wdata = drain_word_reg ? wbuf_reg[0].d1 : wbuf_reg[0].d0;

  dpsram_mem u_mem (
    .clk_i   (CLK_I),
    .en_i    (mem_en),
    .we_i    (mem_we),
    .addr_i  (mem_addr),
    .be_i    (mem_be),
    .wdata_i (mem_wdata),
    .rdata_o (mem_rdata)
  );

  // Newer buffered bytes overlay the array word, oldest entry first
  function automatic logic [WORD_W-1:0] overlay(input logic [WORD_W-1:0] base,
                                                input dpsram_wburst_t ent,
                                                input logic [ADDR_W-1:0] addr,
                                                input logic word);
    logic [WORD_W-1:0] res;
    logic [LANES-1:0]  be;
    logic [WORD_W-1:0] d;
    res = base;
    be  = word ? ent.be1 : ent.be0;
    d   = word ? ent.d1 : ent.d0;
    if (ent.addr == addr) begin
      for (int i = 0; i < LANES; i++) begin
        if (be[i]) begin
          res[i*BYTE_W +: BYTE_W] = d[i*BYTE_W +: BYTE_W];
        end
      end
    end
    return res;
  endfunction : overlay

  wire [WORD_W-1:0] fwd0 = (wbuf_cnt_reg != CNT_RST)
                           ? overlay(mem_rdata, wbuf_reg[0], rd_addr_reg, ret_word_reg)
                           : mem_rdata;
  wire [WORD_W-1:0] fwd1 = (wbuf_cnt_reg == 2'h2)
                           ? overlay(fwd0, wbuf_reg[1], rd_addr_reg, ret_word_reg)
                           : fwd0;

  // Output stage
  logic              arm_reg;
  logic [WORD_W-1:0] aw0_reg, aw1_reg, hold_w1_reg;
  logic              phase_reg;
  // With the input pair timing output, the burst goes out at the very K edge that arms it
  wire               deliver  = single_mode ? (k_rise & fdone_reg) : arm_reg;
  wire [WORD_W-1:0]  src_w0   = single_mode ? fw0_reg : aw0_reg;
  wire [WORD_W-1:0]  src_w1   = single_mode ? fw1_reg : aw1_reg;

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      k_reg  <= 1'b0;
      kn_reg <= 1'b0;
      c_reg  <= 1'b0;
      cn_reg <= 1'b0;
    end else begin
      k_reg  <= K_I;
      kn_reg <= K_N_I;
      c_reg  <= C_I;
      cn_reg <= C_N_I;
    end
  end

  // Write capture: word 0 on K, address and word 1 on K#
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      wr_open_reg <= 1'b0;
      wr_full_reg <= 1'b0;
      wr_reg      <= WBURST_RST;
    end else begin
      if (wbuf_push) begin
        wr_full_reg <= 1'b0;
      end
      if (wr_start && !wr_full_reg) begin
        wr_open_reg <= 1'b1;
        wr_reg.d0   <= WR_DATA_I;
        wr_reg.be0  <= be_pins;
      end else if (kn_rise && wr_open_reg) begin
        wr_open_reg <= 1'b0;
        wr_full_reg <= 1'b1;
        wr_reg.addr <= SHARED_ADDR_IN_I;
        wr_reg.d1   <= WR_DATA_I;
        wr_reg.be1  <= be_pins;
      end
    end
  end

  // Buffer bookkeeping; a pop and a push may share a cycle
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      wbuf_cnt_reg   <= CNT_RST;
      drain_word_reg <= 1'b0;
      wbuf_reg[0]    <= WBURST_RST;
      wbuf_reg[1]    <= WBURST_RST;
    end else begin
      if (drain_word_en) begin
        drain_word_reg <= ~drain_word_reg;
      end
      if (wbuf_pop) begin
        wbuf_reg[0] <= wbuf_reg[1];
      end
      if (wbuf_push) begin
        wbuf_reg[1'(wbuf_cnt_reg - 2'(wbuf_pop))] <= wr_reg;
      end
      wbuf_cnt_reg <= 2'(wbuf_cnt_reg + 2'(wbuf_push) - 2'(wbuf_pop));
    end
  end

  // Read address capture and fetch of both words
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      fetch_state_reg <= FETCH_IDLE;
      rd_addr_reg     <= '0;
      ret_vld_reg     <= 1'b0;
      ret_word_reg    <= 1'b0;
      fw0_reg         <= WORD_RST;
      fw1_reg         <= WORD_RST;
      fdone_reg       <= 1'b0;
    end else begin
      fetch_state_reg <= fetch_state_next;
      ret_vld_reg     <= mem_rd_busy;
      ret_word_reg    <= fetch_word;
      if (rd_start) begin
        rd_addr_reg <= SHARED_ADDR_IN_I;
      end
      if (ret_vld_reg && !ret_word_reg) begin
        fw0_reg <= fwd1;
      end
      if (ret_vld_reg && ret_word_reg) begin
        fw1_reg   <= fwd1;
        fdone_reg <= 1'b1;
      end else if (k_rise) begin
        fdone_reg <= 1'b0;
      end
    end
  end

  // Burst is armed at the K edge after its request, then launched by the output pair
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      arm_reg      <= 1'b0;
      aw0_reg      <= WORD_RST;
      aw1_reg      <= WORD_RST;
      hold_w1_reg  <= WORD_RST;
      phase_reg    <= 1'b0;
      RD_DATA_O    <= WORD_RST;
      RD_DATA_OE_O <= 1'b0;
    end else begin
      if (k_rise) begin
        arm_reg <= fdone_reg & ~single_mode;
        aw0_reg <= fw0_reg;
        aw1_reg <= fw1_reg;
      end else if (out_first && deliver) begin
        arm_reg <= 1'b0;
      end
      if (out_first) begin
        if (deliver) begin
          RD_DATA_O    <= src_w0;
          RD_DATA_OE_O <= 1'b1;
          hold_w1_reg  <= src_w1;
          phase_reg    <= 1'b1;
        end else begin
          RD_DATA_OE_O <= 1'b0;
          phase_reg    <= 1'b0;
        end
      end else if (out_second) begin
        if (phase_reg) begin
          RD_DATA_O <= hold_w1_reg;
          phase_reg <= 1'b0;
        end else begin
          RD_DATA_OE_O <= 1'b0;
        end
      end
    end
  end

endmodule : dpsram_top
`default_nettype wire

// ===== dpsram_pkg.sv
package dpsram_pkg;

  localparam int ADDR_W    = 18;                 // One address per two-word location
  localparam int WORD_W    = 18;
  localparam int BYTE_W    = 9;
  localparam int LANES     = 2;
  localparam int MEM_AW    = ADDR_W + 1;         // Word index: address plus burst bit
  localparam int MEM_DEPTH = 1 << MEM_AW;
  localparam int WBUF_DEPTH = 2;

  localparam logic [WORD_W-1:0] WORD_RST = 18'h00000;
  localparam logic [1:0]        CNT_RST  = 2'h0;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] d0;
    logic [WORD_W-1:0] d1;
    logic [LANES-1:0]  be0;                      // Active high store enables, word 0
    logic [LANES-1:0]  be1;                      // Active high store enables, word 1
  } dpsram_wburst_t;

  localparam dpsram_wburst_t WBURST_RST = '0;

endpackage : dpsram_pkg

// ===== dpsram_mem.sv
`timescale 1ns/1ps
`default_nettype none
module dpsram_mem
  import dpsram_pkg::*;
(
  input  wire logic              clk_i,    // System clock
  input  wire logic              en_i,     // Access this cycle
  input  wire logic              we_i,     // Write when high, read when low
  input  wire logic [MEM_AW-1:0] addr_i,   // Word index
  input  wire logic [LANES-1:0]  be_i,     // Byte lane store enables
  input  wire logic [WORD_W-1:0] wdata_i,  // Write word
  output logic      [WORD_W-1:0] rdata_o   // Read word, one cycle after request
);

  logic [WORD_W-1:0] mem [MEM_DEPTH];

  always_ff @(posedge clk_i) begin
    if (en_i && we_i) begin
      for (int i = 0; i < LANES; i++) begin
        if (be_i[i]) begin
          mem[addr_i][i*BYTE_W +: BYTE_W] <= wdata_i[i*BYTE_W +: BYTE_W];
        end
      end
    end
    if (en_i && !we_i) begin
      rdata_o <= mem[addr_i];
    end
  end

endmodule : dpsram_mem
`default_nettype wire

// ===== dpsram_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module dpsram_chk
  import dpsram_pkg::*;
(
  input wire logic              CLK_I,        // Clock
  input wire logic              SRST_I,       // Reset
  input wire logic              K_I,          // Input clock
  input wire logic              K_N_I,        // Input clock, inverse
  input wire logic              C_I,          // Output clock
  input wire logic              C_N_I,        // Output clock, inverse
  input wire logic              RD_SEL_N_I,   // Read select
  input wire logic [WORD_W-1:0] RD_DATA_O,    // Read data
  input wire logic              RD_DATA_OE_O  // Read enable
);
  logic       k_q, kn_q, c_q, cn_q, first_q, any_q;
  logic       single, rd_req, first_edge, second_edge;
  logic [3:0] since_rd;
  assign single      = C_I & C_N_I & c_q & cn_q;
  assign rd_req      = K_I & ~k_q & ~RD_SEL_N_I;
  assign first_edge  = single ? (K_I & ~k_q) : (C_I & ~c_q);
  assign second_edge = single ? (K_N_I & ~kn_q) : (C_N_I & ~cn_q);
  always_ff @(posedge CLK_I) begin
    {k_q, kn_q, c_q, cn_q} <= {K_I, K_N_I, C_I, C_N_I};
    first_q <= first_edge;
    any_q   <= first_edge | second_edge;
  end
  // Saturates so that an old read cannot alias as a fresh one
  always_ff @(posedge CLK_I) begin
    if (SRST_I) since_rd <= 4'hF;
    else if (rd_req) since_rd <= 4'h0;
    else if (since_rd != 4'hF) since_rd <= since_rd + 4'h1;
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  sequence s_fresh_read;
    K_I && !k_q && !RD_SEL_N_I && since_rd == 4'hF;
  endsequence
  sequence s_quiet;
    !RD_DATA_OE_O [*3];
  endsequence
  a_reset_clears: assert property ($fell(SRST_I) |-> !RD_DATA_OE_O && RD_DATA_O == '0)
    else $error("read port not cleared by reset");
  a_no_early: assert property (s_fresh_read |=> s_quiet)
    else $error("read data before next input clock");
  // Input pair delivers 5 cycles after the request, output pair 6, at a 4-cycle K period;
  // a newer back-to-back read must not hide the one being answered
  a_oe_latency: assert property ($rose(RD_DATA_OE_O) |->
      $past(rd_req, 5) || $past(rd_req, 6))
    else $error("read data without matching request");
  a_burst_len: assert property ($rose(RD_DATA_OE_O) |-> RD_DATA_OE_O [*4])
    else $error("burst shorter than two words");
  a_oe_rise: assert property ($rose(RD_DATA_OE_O) |-> first_q)
    else $error("first word not on first clock");
  a_oe_fall: assert property ($fell(RD_DATA_OE_O) |-> any_q)
    else $error("read port released off a clock edge");
  a_word_hold: assert property (RD_DATA_OE_O && $past(RD_DATA_OE_O) && !any_q |->
      $stable(RD_DATA_O))
    else $error("read word changed between edges");
  a_idle_hold: assert property (!RD_DATA_OE_O && !$past(RD_DATA_OE_O) |->
      $stable(RD_DATA_O))
    else $error("read data moved while released");
endmodule : dpsram_chk

bind dpsram_top dpsram_chk chk (.CLK_I(CLK_I), .SRST_I(SRST_I), .K_I(K_I), .K_N_I(K_N_I),
  .C_I(C_I), .C_N_I(C_N_I), .RD_SEL_N_I(RD_SEL_N_I), .RD_DATA_O(RD_DATA_O),
  .RD_DATA_OE_O(RD_DATA_OE_O));
`default_nettype wire

// ===== dpsram_ctl_mdl.sv
`timescale 1ns/1ps
`default_nettype none
module dpsram_ctl_mdl
  import dpsram_pkg::*;
(
  input  wire logic              clk_i,      // Clock
  input  wire logic              single_i,   // Hold output clocks high
  input  wire logic [WORD_W-1:0] rd_data_i,  // Read data
  input  wire logic              rd_oe_i,    // Read enable
  output logic                   k_o,        // Input clock
  output logic                   k_n_o,      // Input clock, inverse
  output logic                   c_o,        // Output clock
  output logic                   c_n_o,      // Output clock, inverse
  output logic                   rd_sel_n_o, // Read select
  output logic                   wr_sel_n_o, // Write select
  output logic      [ADDR_W-1:0] addr_o,     // Shared address
  output logic      [LANES-1:0]  be_n_o,     // Byte write enables {hi, lo}
  output logic      [WORD_W-1:0] wdata_o     // Write data
);
  initial begin
    {k_o, k_n_o, rd_sel_n_o, wr_sel_n_o, c_o, c_n_o} = 6'h0F;
    addr_o  = '0;
    be_n_o  = 2'h3;
    wdata_o = '0;
  end
  // One input clock period of four cycles; q0, q1 and oe0 belong to the previous request.
  // Unused lines flip each cycle so a stale value can never pass for a fresh one.
  task automatic period(input logic rd, wr, input logic [ADDR_W-1:0] a,
                        input logic [WORD_W-1:0] w0, w1, input logic [LANES-1:0] be0, be1,
                        output logic [WORD_W-1:0] q0, q1, output logic oe0);
    for (int i = 0; i < 4; i++) begin
      k_o        = (i < 2);
      k_n_o      = (i > 1);
      c_o        = single_i | (i == 1) | (i == 2);
      c_n_o      = single_i | (i == 3) | (i == 0);
      rd_sel_n_o = !(rd && i == 0);
      wr_sel_n_o = !(wr && i == 0);
      addr_o     = ((i == 0 && rd) || (i == 2 && wr)) ? a : ~addr_o;
      wdata_o    = (i == 0) ? w0 : (i == 2) ? w1 : ~wdata_o;
      be_n_o     = (i == 0) ? be0 : (i == 2) ? be1 : ~be_n_o;
      @(posedge clk_i);
      @(negedge clk_i);
      if (i == (single_i ? 0 : 1)) begin
        q0  = rd_data_i;
        oe0 = rd_oe_i;
      end
      if (i == (single_i ? 2 : 3)) q1 = rd_data_i;
    end
  endtask : period
endmodule : dpsram_ctl_mdl
`default_nettype wire

// ===== tb_dual_port_ddr_sram_pin_interface.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dual_port_ddr_sram_pin_interface;
  import dpsram_pkg::*;
  logic              clk, srst, single, k, k_n, c, c_n, rd_sel_n, wr_sel_n, oe, oe0, pend;
  logic [ADDR_W-1:0] addr;
  logic [LANES-1:0]  be_n;
  logic [WORD_W-1:0] wdata, rdata, pe0, pe1, q0, q1;
  logic [WORD_W-1:0] mem [MEM_DEPTH];
  int                mismatches, checks_done;

  dpsram_top uut (.CLK_I(clk), .SRST_I(srst), .K_I(k), .K_N_I(k_n), .C_I(c), .C_N_I(c_n),
    .RD_SEL_N_I(rd_sel_n), .WR_SEL_N_I(wr_sel_n), .SHARED_ADDR_IN_I(addr),
    .BYTE_WRITE_LO_N_I(be_n[0]), .BYTE_WRITE_HI_N_I(be_n[1]), .WR_DATA_I(wdata),
    .RD_DATA_O(rdata), .RD_DATA_OE_O(oe));
  dpsram_ctl_mdl ctl (.clk_i(clk), .single_i(single), .rd_data_i(rdata), .rd_oe_i(oe),
    .k_o(k), .k_n_o(k_n), .c_o(c), .c_n_o(c_n), .rd_sel_n_o(rd_sel_n), .wr_sel_n_o(wr_sel_n),
    .addr_o(addr), .be_n_o(be_n), .wdata_o(wdata));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [WORD_W-1:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [WORD_W-1:0] merge(input logic [WORD_W-1:0] old, d,
                                              input logic [LANES-1:0] be);
    return {be[1] ? old[WORD_W-1:BYTE_W] : d[WORD_W-1:BYTE_W],
            be[0] ? old[BYTE_W-1:0] : d[BYTE_W-1:0]};
  endfunction : merge

  // Expected read words are taken before this period's write lands
  task automatic acc(input logic rd, wr, input logic [ADDR_W-1:0] a,
                     input logic [WORD_W-1:0] w0, w1, input logic [LANES-1:0] be0, be1);
    logic [WORD_W-1:0] r0, r1;
    r0 = mem[{a, 1'b0}];
    r1 = mem[{a, 1'b1}];
    ctl.period(rd, wr, a, w0, w1, be0, be1, q0, q1, oe0);
    check(WORD_W'(oe0), WORD_W'(pend));
    if (pend) begin
      check(q0, pe0);
      check(q1, pe1);
    end
    if (wr) begin
      mem[{a, 1'b0}] = merge(r0, w0, be0);
      mem[{a, 1'b1}] = merge(r1, w1, be1);
    end
    pend = rd;
    pe0  = r0;
    pe1  = r1;
  endtask : acc

  task automatic idle;
    acc(1'b0, 1'b0, 18'h00005, 18'h3FFFF, 18'h3FFFF, 2'h0, 2'h0);
  endtask : idle

  task automatic t_single;
    acc(1'b0, 1'b1, 18'h00005, 18'h2A5A5, 18'h15A5A, 2'h0, 2'h0);
    acc(1'b1, 1'b0, 18'h00005, 18'h00000, 18'h00000, 2'h3, 2'h3);
    acc(1'b1, 1'b1, 18'h00005, 18'h3C3C3, 18'h03C3C, 2'h0, 2'h0);
    acc(1'b1, 1'b0, 18'h00005, 18'h00000, 18'h00000, 2'h3, 2'h3);
    idle();
    $display("test single clock pair done");
  endtask : t_single

  task automatic t_cmode;
    srst   = 1'b1;
    single = 1'b0;
    idle();
    srst   = 1'b0;
    // Edge detectors need one clock after release before the first request
    idle();
    acc(1'b0, 1'b1, 18'h3FFFF, 18'h3FFFF, 18'h3FFFF, 2'h0, 2'h0);
    for (int b = 0; b < 4; b++)
      acc(1'b1, 1'b1, 18'h3FFFF, 18'h0AB00 + 18'(b), 18'h15400 + 18'(b), 2'(b), ~2'(b));
    acc(1'b1, 1'b0, 18'h3FFFF, 18'h00000, 18'h00000, 2'h3, 2'h3);
    idle();
    $display("test output clock pair and byte writes done");
  endtask : t_cmode

  task automatic t_quiet;
    repeat (4) idle();
    acc(1'b1, 1'b0, 18'h00005, 18'h00000, 18'h00000, 2'h3, 2'h3);
    idle();
    $display("test deselected bus done");
  endtask : t_quiet

  task automatic t_reset;
    acc(1'b1, 1'b0, 18'h3FFFF, 18'h00000, 18'h00000, 2'h3, 2'h3);
    srst = 1'b1;
    pend = 1'b0;
    idle();
    check(rdata, WORD_RST);
    srst = 1'b0;
    idle();
    $display("test reset during burst done");
  endtask : t_reset

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test

  initial begin
    repeat (2000) @(posedge clk);
    mismatches++;
    stop_test();
  end

  initial begin
    srst        = 1'b1;
    single      = 1'b1;
    pend        = 1'b0;
    mismatches  = 0;
    checks_done = 0;
    repeat (12) @(negedge clk);
    srst = 1'b0;
    repeat (2) @(negedge clk);
    t_single();
    t_cmode();
    t_quiet();
    t_reset();
    stop_test();
  end
endmodule : tb_dual_port_ddr_sram_pin_interface
`default_nettype wire
